// [sum_manager.sv]
// channel status and user bit buffer manager behind an avalon-mm slave
`timescale 1ns/1ns
`include "sum_defs.svh"

module sum_manager (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_u_bit,
    input  wire logic        rx_u_strobe,
    input  wire logic        rx_block_start,
    input  wire logic        tx_u_request,
    output logic             tx_u_bit,
    output logic             irq
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    sum_pkg::sum_state_t s;
    sum_pkg::sum_state_t n;

    logic [15:0] cs_mem [0:23];
    logic [15:0] ud_mem [0:23];
    logic [15:0] ue_mem [0:23];
    logic [15:0] uf_mem [0:23];
    logic [8:0]  fifo_mem [0:255];

    logic        cs_we;
    logic [15:0] cs_wd;
    logic        ue_we;
    logic        ud_we;
    logic        de_copy;
    logic        ef_copy;
    logic        f_we;
    logic [7:0]  f_wa;
    logic [8:0]  f_wd;
    logic        rx_ev;
    logic        tx_ev;
    logic        fifo_ovf;
    logic        tx_load;
    logic [7:0]  full_byte;
    logic [15:0] cs_word;

    function automatic logic sum_hit(input logic [7:0] a, input logic [2:0] region);
        sum_hit = (a[7:5] == region) && (a[4:0] < `SUM_WORDS);
    endfunction

    function automatic logic [3:0] sum_bitpos(input logic [8:0] cnt);
        sum_bitpos = ~cnt[3:0];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = s;
        cs_we     = 1'b0;
        cs_wd     = 16'h0000;
        ue_we     = 1'b0;
        ud_we     = 1'b0;
        de_copy   = 1'b0;
        ef_copy   = 1'b0;
        f_we      = 1'b0;
        f_wa      = s.wr_ptr;
        f_wd      = 9'h000;
        fifo_ovf  = 1'b0;
        tx_load   = 1'b0;
        full_byte = {s.iu_sh, s.rxb2};
        cs_word   = cs_mem[avs_address[4:0]];
        // two flops on every pin before any logic looks at it
        n.rxb1 = rx_u_bit;
        n.rxb2 = s.rxb1;
        n.rxs1 = rx_u_strobe;
        n.rxs2 = s.rxs1;
        n.rxs3 = s.rxs2;
        n.rbk1 = rx_block_start;
        n.rbk2 = s.rbk1;
        n.txr1 = tx_u_request;
        n.txr2 = s.txr1;
        n.txr3 = s.txr2;
        // edges come from the second and third flop; the first one may still be settling
        rx_ev  = s.rxs2 & ~s.rxs3;
        tx_ev  = s.txr2 & ~s.txr3;

        // avalon slave: one wait cycle, read data registered in it
        n.waitreq = 1'b1;
        if ((avs_read || avs_write) && s.waitreq) begin
            n.waitreq = 1'b0;
            n.rdata   = 32'h00000000;
            if (avs_address == `SUM_REG_CTRL) begin
                n.rdata[4:0] = {s.irq_en, s.umode, s.chan_b, s.two_byte};
            end else if (avs_address == `SUM_REG_STAT) begin
                n.rdata[0] = s.ovf;
            end else if (avs_address == `SUM_REG_QSUB) begin
                n.rdata[15:0] = s.q_shift;
            end else if (avs_address == `SUM_REG_OFL) begin
                n.rdata[3:0] = s.min_fill;
            end else if (sum_hit(avs_address, `SUM_CS_REGION)) begin
                if (s.two_byte) begin
                    n.rdata[15:0] = cs_word;
                end else begin
                    n.rdata[7:0] = s.chan_b ? cs_word[7:0] : cs_word[15:8];
                end
            end else if (sum_hit(avs_address, `SUM_UB_REGION)) begin
                n.rdata[15:0] = ue_mem[avs_address[4:0]];
            end
        end
        if (avs_write && !s.waitreq && avs_byteenable[0]) begin
            if (avs_address == `SUM_REG_CTRL) begin
                n.two_byte = avs_writedata[`SUM_CTRL_TWO_BYTE];
                n.chan_b   = avs_writedata[`SUM_CTRL_CHAN_B];
                n.umode    = sum_pkg::sum_umode_t'(avs_writedata[`SUM_CTRL_UMODE_HI:`SUM_CTRL_UMODE_LO]);
                n.irq_en   = avs_writedata[`SUM_CTRL_IRQ_EN];
            end else if (avs_address == `SUM_REG_STAT) begin
                if (avs_writedata[`SUM_STAT_OVF]) begin
                    n.ovf = 1'b0;
                end
            end else if (sum_hit(avs_address, `SUM_CS_REGION)) begin
                cs_we = 1'b1;
                // one-byte mode copies the byte to both channels
                cs_wd = s.two_byte ? avs_writedata[15:0] : {avs_writedata[7:0], avs_writedata[7:0]};
            end else if (sum_hit(avs_address, `SUM_UB_REGION)) begin
                ue_we = 1'b1;
            end
        end

        // receive side
        if (rx_ev) begin
            if (s.umode == sum_pkg::SUM_UM_BLOCK) begin
                ud_we = 1'b1;
                n.rx_cnt = s.rbk2 ? 9'd1 : ((s.rx_cnt == `SUM_BLOCK_LAST) ? 9'd0 : s.rx_cnt + 9'd1);
                de_copy = !s.rbk2 && (s.rx_cnt == `SUM_BLOCK_LAST);
            end
            if (s.iu_bits != 4'd0) begin
                n.iu_sh   = {s.iu_sh[5:0], s.rxb2};
                n.iu_bits = s.iu_bits + 4'd1;
                if (s.iu_bits == `SUM_IU_LAST) begin
                    n.iu_bits  = 4'd0;
                    n.zero_run = 4'd0;
                    n.in_msg   = 1'b1;
                    n.q_shift  = {s.q_shift[14:0], full_byte[6]};
                    if (s.umode == sum_pkg::SUM_UM_CONS) begin
                        // one slot stays unused so that a full ring never looks empty
                        if (s.wr_ptr + 8'h01 == s.rd_ptr) begin
                            fifo_ovf = 1'b1;
                        end else begin
                            f_we     = 1'b1;
                            f_wd     = {1'b0, full_byte};
                            n.wr_ptr = s.wr_ptr + 8'h01;
                            n.units  = (s.units == `SUM_UNITS_SAT) ? s.units : s.units + 8'h01;
                        end
                    end
                end
            end else if (s.rxb2) begin
                n.iu_bits = 4'd1;
                n.iu_sh   = 7'h01;
                if (s.in_msg && s.zero_run <= `SUM_FILL_MAX && s.zero_run < s.min_fill) begin
                    n.min_fill = s.zero_run;
                end
            end else begin
                if (s.zero_run != `SUM_GAP_ZEROS) begin
                    n.zero_run = s.zero_run + 4'd1;
                end
                if (s.zero_run == `SUM_FILL_MAX && s.in_msg) begin
                    n.in_msg = 1'b0;
                    n.units  = 8'h00;
                    if (s.units >= `SUM_MSG_MIN && s.units <= `SUM_MSG_MAX) begin
                        n.commit_ptr = s.wr_ptr;
                        f_we = (s.umode == sum_pkg::SUM_UM_CONS);
                        f_wa = s.wr_ptr - 8'h01;
                        f_wd = {1'b1, fifo_mem[s.wr_ptr - 8'h01][7:0]};
                    end else begin
                        n.wr_ptr = s.commit_ptr;
                    end
                end
            end
        end

        // transmit side
        if (tx_ev) begin
            case (s.umode)
                sum_pkg::SUM_UM_BLOCK: begin
                    n.tx_u_bit = uf_mem[s.tx_cnt[8:4]][sum_bitpos(s.tx_cnt)];
                    n.tx_cnt   = (s.tx_cnt == `SUM_BLOCK_LAST) ? 9'd0 : s.tx_cnt + 9'd1;
                    ef_copy    = (s.tx_cnt == `SUM_BLOCK_LAST);
                end
                sum_pkg::SUM_UM_CONS: begin
                    if (s.tx_bits != 4'd0) begin
                        n.tx_u_bit = s.tx_sh[7];
                        n.tx_sh    = {s.tx_sh[6:0], 1'b0};
                        n.tx_bits  = s.tx_bits - 4'd1;
                        if (s.tx_bits == 4'd1) begin
                            // a gap after the last unit keeps messages apart at the far end
                            n.tx_fill = s.tx_last ? `SUM_GAP_ZEROS : s.min_fill;
                        end
                    end else if (s.tx_fill != 4'd0) begin
                        n.tx_u_bit = 1'b0;
                        n.tx_fill  = s.tx_fill - 4'd1;
                    end else if (s.rd_ptr != s.commit_ptr) begin
                        tx_load    = 1'b1;
                        n.tx_u_bit = fifo_mem[s.rd_ptr][7];
                        n.tx_sh    = {fifo_mem[s.rd_ptr][6:0], 1'b0};
                        n.tx_last  = fifo_mem[s.rd_ptr][8];
                        n.tx_bits  = `SUM_IU_LAST;
                        n.rd_ptr   = s.rd_ptr + 8'h01;
                    end else begin
                        n.tx_u_bit = 1'b0;
                    end
                end
                default: begin
                    n.tx_u_bit = 1'b0;
                end
            endcase
        end

        // outside consumer mode, and on an overwrite, the fifo starts empty
        if (fifo_ovf || s.umode != sum_pkg::SUM_UM_CONS) begin
            n.wr_ptr     = 8'h00;
            n.rd_ptr     = 8'h00;
            n.commit_ptr = 8'h00;
            n.tx_bits    = 4'd0;
            n.tx_fill    = 4'd0;
            n.units      = 8'h00;
            n.in_msg     = 1'b0;
            n.min_fill   = `SUM_FILL_MAX;
        end
        if (fifo_ovf) begin
            n.ovf = 1'b1;
        end
        n.irq = s.ovf & s.irq_en;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s          <= '0;
            s.waitreq  <= 1'b1;
            s.min_fill <= `SUM_FILL_MAX;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // memories
    // ----------------------------------------------------------------
    // no reset on the buffers; software initialises what it transmits
    always_ff @(posedge clk) begin
        if (cs_we) begin
            cs_mem[avs_address[4:0]] <= cs_wd;
        end
        if (ud_we) begin
            ud_mem[s.rbk2 ? 5'd0 : s.rx_cnt[8:4]][s.rbk2 ? 4'hf : sum_bitpos(s.rx_cnt)] <= s.rxb2;
        end
        for (int i = 0; i < 24; i++) begin
            if (de_copy) begin
                ue_mem[i] <= ud_mem[i];
            end
            if (ef_copy) begin
                uf_mem[i] <= ue_mem[i];
            end
        end
        // the last received bit is stored at the very edge of the copy, so it joins the copy here
        if (de_copy) begin
            ue_mem[s.rx_cnt[8:4]] <= {ud_mem[s.rx_cnt[8:4]][15:1], s.rxb2};
        end
        // host write wins over a block copy in the same cycle
        if (ue_we) begin
            ue_mem[avs_address[4:0]] <= avs_writedata[15:0];
        end
        if (f_we) begin
            fifo_mem[f_wa] <= f_wd;
        end
    end

    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign tx_u_bit        = s.tx_u_bit;
    assign irq             = s.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_req_first;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence seq_cs_one_read;
        avs_read && avs_waitrequest && !s.two_byte && sum_hit(avs_address, `SUM_CS_REGION);
    endsequence

    a_bus_one_wait: assert property (seq_req_first |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_cs_one_byte: assert property (seq_cs_one_read |=> avs_readdata[31:8] == 24'h000000)
        else $error("one-byte read returned more than a byte");
    // the stored word is checked, not the write data path
    a_cs_write_both: assert property (cs_we && !s.two_byte |=>
        cs_mem[$past(avs_address[4:0])] == {2{$past(avs_writedata[7:0])}})
        else $error("one-byte write did not fill both channels");
    a_zero_mode_out: assert property (tx_ev && s.umode == sum_pkg::SUM_UM_ZERO |=> !tx_u_bit)
        else $error("zero mode sent a one");
    a_fifo_ovf_reset: assert property (fifo_ovf |=> s.wr_ptr == 8'h00 && s.rd_ptr == 8'h00 && s.ovf)
        else $error("overwrite did not reset fifo");
    a_ovf_irq_out: assert property (s.ovf && s.irq_en |=> irq)
        else $error("enabled overwrite gave no interrupt");
    a_load_committed: assert property (tx_load |->
        s.rd_ptr != s.commit_ptr && 8'(s.commit_ptr - s.rd_ptr) <= 8'(s.wr_ptr - s.rd_ptr))
        else $error("fifo read beyond committed message");
    a_empty_sends_zero: assert property (tx_ev && s.umode == sum_pkg::SUM_UM_CONS && s.tx_bits == 4'd0
        && s.tx_fill == 4'd0 && s.rd_ptr == s.commit_ptr |=> !tx_u_bit)
        else $error("empty fifo sent a one");
    a_fill_bounded: assert property (s.min_fill <= `SUM_FILL_MAX && ($past(s.min_fill) >= s.min_fill
        || $past(fifo_ovf) || s.umode != sum_pkg::SUM_UM_CONS || s.min_fill == `SUM_FILL_MAX))
        else $error("output filler grew or exceeded eight");
    a_q_collect: assert property (rx_ev && s.iu_bits == `SUM_IU_LAST |=> s.q_shift[0] == $past(s.iu_sh[5]))
        else $error("subcode bit not collected");

    // ----------------------------------------------------------------
    // user stream checks
    // ----------------------------------------------------------------
    sequence seq_gap_zero;
        rx_ev && s.iu_bits == 4'd0 && !s.rxb2 && s.zero_run == `SUM_FILL_MAX;
    endsequence

    a_fifo_units: assert property (f_we |->
        rx_ev && s.umode == sum_pkg::SUM_UM_CONS && (s.iu_bits == `SUM_IU_LAST || s.zero_run == `SUM_FILL_MAX))
        else $error("fifo written outside a unit or message end");
    a_gap_ends_msg: assert property (seq_gap_zero |=> !s.in_msg)
        else $error("ninth zero did not end the message");
    a_rsvd_sends_zero: assert property (tx_ev && s.umode == sum_pkg::SUM_UM_RSVD |=> !tx_u_bit)
        else $error("reserved mode sent a one");
    a_block_wrap: assert property (tx_ev && s.umode == sum_pkg::SUM_UM_BLOCK && s.tx_cnt == `SUM_BLOCK_LAST
        |=> s.tx_cnt == 9'd0)
        else $error("transmit block did not wrap after its last bit");
    a_irq_disabled: assert property (!s.irq_en |=> !irq)
        else $error("interrupt raised while disabled");
    a_ovf_sticky: assert property (s.ovf && !(avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == `SUM_REG_STAT && avs_writedata[`SUM_STAT_OVF]) |=> s.ovf)
        else $error("overwrite flag dropped without a clear");
    // a block copy on the answer edge would change the word, so such cycles are left out
    a_ub_two_byte: assert property (avs_read && avs_waitrequest && !de_copy
        && sum_hit(avs_address, `SUM_UB_REGION) |=> avs_readdata == {16'h0000, ue_mem[$past(avs_address[4:0])]})
        else $error("user buffer read was not a full word");
endmodule // sum_manager

// [sum_defs.svh]
// offsets, field positions, reset values and counts of the status and user bit manager
`ifndef SUM_DEFS_SVH
`define SUM_DEFS_SVH
// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define SUM_REG_CTRL      8'h00
`define SUM_REG_STAT      8'h01
`define SUM_REG_QSUB      8'h02
`define SUM_REG_OFL       8'h03
`define SUM_CS_REGION     3'b001
`define SUM_UB_REGION     3'b010
`define SUM_WORDS         5'd24
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SUM_CTRL_TWO_BYTE 0
`define SUM_CTRL_CHAN_B   1
`define SUM_CTRL_UMODE_LO 2
`define SUM_CTRL_UMODE_HI 3
`define SUM_CTRL_IRQ_EN   4
`define SUM_STAT_OVF      0
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SUM_CTRL_RST      5'h00
`define SUM_BLOCK_LAST    9'd383
`define SUM_IU_LAST       4'd7
`define SUM_GAP_ZEROS     4'd9
`define SUM_FILL_MAX      4'd8
`define SUM_MSG_MIN       8'd3
`define SUM_MSG_MAX       8'd129
`define SUM_UNITS_SAT     8'd130
`endif

// [sum_pkg.sv]
// types of the status and user bit manager
package sum_pkg;
    typedef enum logic [1:0] {
        SUM_UM_ZERO  = 2'b00,
        SUM_UM_BLOCK = 2'b01,
        SUM_UM_RSVD  = 2'b10,
        SUM_UM_CONS  = 2'b11
    } sum_umode_t;

    typedef struct packed {
        logic             waitreq;
        logic [31:0]      rdata;
        logic             two_byte;
        logic             chan_b;
        sum_umode_t       umode;
        logic             irq_en;
        logic             ovf;
        logic             irq;
        logic             rxb1;
        logic             rxb2;
        logic             rxs1;
        logic             rxs2;
        logic             rxs3;
        logic             rbk1;
        logic             rbk2;
        logic             txr1;
        logic             txr2;
        logic             txr3;
        logic [8:0]       rx_cnt;
        logic [8:0]       tx_cnt;
        logic [3:0]       zero_run;
        logic [6:0]       iu_sh;
        logic [3:0]       iu_bits;
        logic             in_msg;
        logic [7:0]       units;
        logic [3:0]       min_fill;
        logic [7:0]       wr_ptr;
        logic [7:0]       commit_ptr;
        logic [7:0]       rd_ptr;
        logic [7:0]       tx_sh;
        logic [3:0]       tx_bits;
        logic [3:0]       tx_fill;
        logic             tx_last;
        logic [15:0]      q_shift;
        logic             tx_u_bit;
    } sum_state_t;
endpackage

// [sum_far_model.sv]
// far side model: user bit source of the receiver and user bit sink of the transmitter
`timescale 1ns/1ns

module sum_far_model (
    input  wire logic clk,
    output logic      rx_u_bit,
    output logic      rx_u_strobe,
    output logic      rx_block_start,
    output logic      tx_u_request,
    input  wire logic tx_u_bit
);
    initial begin
        rx_u_bit       = 1'b0;
        rx_u_strobe    = 1'b0;
        rx_block_start = 1'b0;
        tx_u_request   = 1'b0;
    end

    // ------------------------------------------------
    // receive side: one bit per frame strobe
    // ------------------------------------------------
    // the line flips once the hold ends so a stale bit never looks valid
    task automatic send_bit(input logic v, input logic first);
        @(posedge clk);
        rx_u_bit       <= v;
        rx_block_start <= first;
        @(posedge clk);
        rx_u_strobe    <= 1'b1;
        repeat (3) @(posedge clk);
        rx_u_strobe    <= 1'b0;
        @(posedge clk);
        rx_u_bit       <= ~v;
        rx_block_start <= 1'b0;
    endtask

    // ------------------------------------------------
    // transmit side: ask for the next bit, take it once settled
    // ------------------------------------------------
    task automatic pull_bit(output logic v);
        @(posedge clk);
        tx_u_request <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        v = tx_u_bit;
        @(posedge clk);
        tx_u_request <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule // sum_far_model

// [sum_manager_tb_top.sv]
// self-checking testbench of the status and user bit manager
`timescale 1ns/1ns
`include "sum_defs.svh"

module sum_manager_tb_top;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_u_bit;
    logic        rx_u_strobe;
    logic        rx_block_start;
    logic        tx_u_request;
    logic        tx_u_bit;
    logic        irq;
    int          n_fail;
    int          compares;
    int          cycles;
    int          i;
    logic [31:0] rd;
    logic [63:0] got;
    logic        b;

    sum_manager DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_u_bit(rx_u_bit),
        .rx_u_strobe(rx_u_strobe), .rx_block_start(rx_block_start), .tx_u_request(tx_u_request),
        .tx_u_bit(tx_u_bit), .irq(irq));

    sum_far_model u_far (.clk(clk), .rx_u_bit(rx_u_bit), .rx_u_strobe(rx_u_strobe),
        .rx_block_start(rx_block_start), .tx_u_request(tx_u_request), .tx_u_bit(tx_u_bit));

    always #20 clk = ~clk;

    // a hang costs a mismatch; the whole run needs about 20000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            results();
        end
    end

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic results();
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        compares = compares + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // avalon cycle: held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clk);
        // values read right at the edge are those before it; a hang is left to the bench timeout
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] m, input logic cb, input logic tb, input logic ie);
        return {27'h0, ie, m, cb, tb};
    endfunction

    task automatic unit(input logic [7:0] v, input int fill);
        for (int j = 7; j >= 0; j--) u_far.send_bit(v[j], 1'b0);
        repeat (fill) u_far.send_bit(1'b0, 1'b0);
    endtask

    task automatic pull_n(input int n);
        got = 64'h0;
        repeat (n) begin
            u_far.pull_bit(b);
            got = {got[62:0], b};
        end
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        chk(tx_u_bit, 1'b0);
        rdc(`SUM_REG_CTRL, 32'(`SUM_CTRL_RST));
        rdc(`SUM_REG_OFL, 32'(`SUM_FILL_MAX));
        bus(1'b1, 8'h38, 32'h0000_00ff);
        rdc(8'h38, 32'h0);
    endtask

    task automatic t_cs();
        bus(1'b1, `SUM_REG_CTRL, cw(2'b00, 1'b0, 1'b1, 1'b0));
        bus(1'b1, 8'h20, 32'h0000_a1b2);
        bus(1'b1, 8'h37, 32'h0000_c3d4);
        rdc(8'h20, 32'h0000_a1b2);
        rdc(8'h37, 32'h0000_c3d4);
        bus(1'b1, `SUM_REG_CTRL, cw(2'b00, 1'b0, 1'b0, 1'b0));
        rdc(8'h20, 32'h0000_00a1);
        bus(1'b1, `SUM_REG_CTRL, cw(2'b00, 1'b1, 1'b0, 1'b0));
        rdc(8'h37, 32'h0000_00d4);
        bus(1'b1, 8'h25, 32'h0000_775e);
        rdc(8'h25, 32'h0000_005e);
        bus(1'b1, `SUM_REG_CTRL, cw(2'b00, 1'b0, 1'b1, 1'b0));
        rdc(8'h25, 32'h0000_5e5e);
    endtask

    task automatic t_block();
        logic [15:0] pat;
        pat = 16'h3c96;
        bus(1'b1, `SUM_REG_CTRL, cw(sum_pkg::SUM_UM_BLOCK, 1'b0, 1'b0, 1'b0));
        bus(1'b1, 8'h40, 32'h0000_a5c3);
        rdc(8'h40, 32'h0000_a5c3);
        pull_n(384);
        pull_n(16);
        chk(got, 64'ha5c3);
        for (i = 0; i < 384; i++) u_far.send_bit(i < 16 ? pat[15 - i] : 1'b0, i == 0);
        rdc(8'h40, 32'h0000_3c96);
        rdc(8'h41, 32'h0);
        rdc(8'h57, 32'h0);
    endtask

    task automatic t_zero();
        for (int m = 0; m < 4; m += 2) begin
            bus(1'b1, `SUM_REG_CTRL, cw(m[1:0], 1'b0, 1'b0, 1'b0));
            unit(8'hff, 9);
            pull_n(16);
            chk(got, 64'h0);
        end
    endtask

    task automatic t_cons();
        bus(1'b1, `SUM_REG_CTRL, cw(sum_pkg::SUM_UM_CONS, 1'b0, 1'b0, 1'b0));
        pull_n(8);
        chk(got, 64'h0);
        unit(8'h9a, 3);
        unit(8'hb3, 9);
        unit(8'hc5, 2);
        unit(8'h81, 2);
        pull_n(8);
        chk(got, 64'h0);
        unit(8'hff, 12);
        bus(1'b0, `SUM_REG_QSUB, 32'h0);
        chk(rd[4:0], 5'b00101);
        rdc(`SUM_REG_OFL, 32'h2);
        i = 0;
        b = 1'b0;
        while (b !== 1'b1 && i < 64) begin
            u_far.pull_bit(b);
            i++;
        end
        pull_n(36);
        chk({1'b1, got[35:0]}, {8'hc5, 2'b00, 8'h81, 2'b00, 8'hff, 9'h0});
    endtask

    task automatic t_ovf();
        bus(1'b1, `SUM_REG_CTRL, cw(sum_pkg::SUM_UM_CONS, 1'b0, 1'b0, 1'b1));
        for (i = 0; i < 129; i++) unit(8'h80, (i == 128) ? 9 : 0);
        rdc(`SUM_REG_STAT, 32'h0);
        for (i = 129; i < 258; i++) unit(8'h80, (i == 257) ? 9 : 0);
        rdc(`SUM_REG_STAT, 32'h1);
        @(negedge clk);
        chk(irq, 1'b1);
        pull_n(24);
        chk(got, 64'h0);
        bus(1'b1, `SUM_REG_STAT, 32'h1);
        rdc(`SUM_REG_STAT, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
    endtask

    initial begin
        clk            = 1'b0;
        sys_rst        = 1'b1;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_byteenable = 4'hf;
        avs_writedata  = 32'h0;
        n_fail         = 0;
        compares       = 0;
        cycles         = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_cs();
        t_block();
        t_zero();
        t_cons();
        t_ovf();
        results();
    end
endmodule // sum_manager_tb_top
